//--- pkg/cpmb_defines.svh
// Offsets, field positions, masks and reset values of the message buffers
`ifndef CPMB_DEFINES_SVH
`define CPMB_DEFINES_SVH
`define CPMB_NUM_BUF       6
`define CPMB_NUM_BYTES     8
`define CPMB_ADDR_W        8
`define CPMB_BUF_STRIDE_SH 4
`define CPMB_OFS_ID_HIGH   4'h0
`define CPMB_OFS_ID_LOW    4'h1
`define CPMB_OFS_EXT_HIGH  4'h2
`define CPMB_OFS_EXT_LOW   4'h3
`define CPMB_OFS_LENGTH    4'h4
`define CPMB_OFS_DATA0     4'h8
`define CPMB_ADDR_BSEL     8'h60
`define CPMB_ADDR_FULL     8'h61
`define CPMB_DIR_LSB       2
`define CPMB_IDL_SRR       4
`define CPMB_IDL_EXT       3
`define CPMB_LEN_RTR       6
`define CPMB_MASK_IDL_RX   8'hfb
`define CPMB_MASK_IDL_TX   8'heb
`define CPMB_MASK_LEN      8'h4f
`define CPMB_MODE_LEGACY   2'h0
`define CPMB_MODE_ENH1     2'h1
`define CPMB_MODE_ENH2     2'h2
`define CPMB_BSEL_RESET    6'h00
`endif

//--- pkg/cpmb_pkg.sv
// Types shared by the programmable message buffer block
package cpmb_pkg;
`include "cpmb_defines.svh"

   typedef enum logic [3:0] {
      CPMB_REG_NONE,
      CPMB_REG_ID_HIGH,
      CPMB_REG_ID_LOW,
      CPMB_REG_EXT_HIGH,
      CPMB_REG_EXT_LOW,
      CPMB_REG_LENGTH,
      CPMB_REG_DATA,
      CPMB_REG_BSEL,
      CPMB_REG_FULL
   } cpmb_reg_e;

   typedef struct packed {
      cpmb_reg_e  kind;
      logic [2:0] buf_idx;
      logic [2:0] byte_idx;
   } cpmb_dec_s;

   typedef logic [`CPMB_NUM_BUF-1:0][7:0] cpmb_bytes_t;

   typedef struct packed {
      cpmb_bytes_t                                  id_high;
      cpmb_bytes_t                                  id_low;
      cpmb_bytes_t                                  ext_high;
      cpmb_bytes_t                                  ext_low;
      cpmb_bytes_t                                  length;
      logic [`CPMB_NUM_BUF-1:0][`CPMB_NUM_BYTES-1:0][7:0] payload;
      logic [`CPMB_NUM_BUF-1:0]                     tx_dir;
      logic [`CPMB_NUM_BUF-1:0]                     rx_full;
      logic [7:0]                                   rd_data;
      logic                                         rx_accept;
      logic [28:0]                                  tx_id;
      logic                                         tx_ext;
      logic                                         tx_rtr;
      logic [3:0]                                   tx_dlc;
      logic [63:0]                                  tx_data;
   } cpmb_state_s;
endpackage : cpmb_pkg

//--- rtl/cpmb_top.sv
// Six programmable transmit/receive CAN message buffers with register port
//
// Overview of operation
// - Direction bit 1 makes a buffer transmit, 0 makes it receive.
// - Buffer select bits 1 and 0 are absent and read zero.
// - Buffer registers and select register work only in modes 1 and 2.
// - Identifier bytes are read-only in receive, read-write in transmit.
// - Id high byte holds standard bits 10..3 or extended bits 28..21.
// - Receive id low bits 7..5 hold standard 2..0 or extended 20..18.
// - Transmit id low bits 7..5 follow the extended-select bit likewise.
// - Receive id low bit 4 reports substitute remote request of extended frames.
// - Id low bit 3 flags an extended frame; zero for standard.
// - Transmit id low bit 4 and bit 2 in both directions read zero.
// - Extended bits 17..16 in id low, 15..8 and 7..0 in extended bytes.
// - Eight payload bytes per buffer, read-only in receive mode.
// - Payload bytes are read-write in transmit mode and feed sending.
// - Receive length bit 6 flags remote request; bit 7 reads zero.
// - Receive length bits 5 and 4 always read zero.
// - Length code 0..8 means that many bytes; 9..15 reserved.
// - Transmit length bit 6 selects the remote request bit sent.
// - Transmit length bits 7, 5 and 4 read zero.
// - Full flag set on storing; no new message until software clears it.
// - Transmit buffer registers are read-only while sending is pending.
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps

module cpmb_top
   import cpmb_pkg::*;
(
   input  wire logic        i_sys_clk,     // System clock, 125 MHz
   input  wire logic        i_reset,       // Synchronous reset, active high
   input  wire logic [1:0]  i_op_mode,     // Controller operating mode
   input  wire logic [7:0]  i_addr,        // Register address
   input  wire logic [7:0]  i_wdata,       // Register write data
   input  wire logic        i_wr,          // Register write strobe
   input  wire logic        i_rd,          // Register read strobe
   output logic      [7:0]  o_rdata,       // Read data, cycle after strobe
   input  wire logic [5:0]  i_tx_locked,   // Send pending or in progress
   input  wire logic        i_rx_store,    // Engine offers a received frame
   input  wire logic [2:0]  i_rx_buf,      // Target buffer of that frame
   input  wire logic [28:0] i_rx_id,       // Identifier, standard in 10..0
   input  wire logic        i_rx_ext,      // Frame has extended identifier
   input  wire logic        i_rx_srr,      // Substitute remote request bit
   input  wire logic        i_rx_rtr,      // Remote transmission request
   input  wire logic [3:0]  i_rx_dlc,      // Received length code
   input  wire logic [63:0] i_rx_data,     // Payload, byte 0 in 7..0
   output logic             o_rx_accept,   // Frame stored, one-cycle pulse
   output logic      [5:0]  o_rx_full,     // Per-buffer full flags
   output logic      [5:0]  o_buf_tx_dir,  // Per-buffer transmit direction
   input  wire logic [2:0]  i_tx_sel,      // Buffer the engine wants to send
   output logic      [28:0] o_tx_id,       // Its identifier
   output logic             o_tx_ext,      // Its extended-select bit
   output logic             o_tx_rtr,      // Its remote request select
   output logic      [3:0]  o_tx_dlc,      // Its length code
   output logic      [63:0] o_tx_data      // Its payload, byte 0 in 7..0
);

   // Address decode shared by the read and write paths
   function automatic cpmb_dec_s cpmb_decode(input logic [7:0] addr);
      cpmb_dec_s d;
      logic [3:0] ofs;

      // No register by default; indices straight from the address
      d.kind     = CPMB_REG_NONE;
      d.buf_idx  = addr[6:4];
      d.byte_idx = addr[2:0];
      ofs        = addr[3:0];

      // Fixed registers first, then offsets inside one buffer
      if (addr == `CPMB_ADDR_BSEL)
      begin
         d.kind = CPMB_REG_BSEL;
      end
      else if (addr == `CPMB_ADDR_FULL)
      begin
         d.kind = CPMB_REG_FULL;
      end
      // Nothing but the select and full registers lives above the sixth buffer
      else if (addr[7] || (addr[6:4] >= 3'(`CPMB_NUM_BUF)))
      begin
         d.kind = CPMB_REG_NONE;
      end
      else if (ofs == `CPMB_OFS_ID_HIGH)
      begin
         d.kind = CPMB_REG_ID_HIGH;
      end
      else if (ofs == `CPMB_OFS_ID_LOW)
      begin
         d.kind = CPMB_REG_ID_LOW;
      end
      else if (ofs == `CPMB_OFS_EXT_HIGH)
      begin
         d.kind = CPMB_REG_EXT_HIGH;
      end
      else if (ofs == `CPMB_OFS_EXT_LOW)
      begin
         d.kind = CPMB_REG_EXT_LOW;
      end
      else if (ofs == `CPMB_OFS_LENGTH)
      begin
         d.kind = CPMB_REG_LENGTH;
      end
      // Offsets 5 to 7 stay holes and read zero
      else if (ofs >= `CPMB_OFS_DATA0)
      begin
         d.kind = CPMB_REG_DATA;
      end
      return d;
   endfunction : cpmb_decode

   // Buffer index valid for the six buffers
   function automatic logic cpmb_buf_ok(input logic [2:0] idx);
      return idx < 3'(`CPMB_NUM_BUF);
   endfunction : cpmb_buf_ok

   // Whole block state and its next value
   cpmb_state_s st_reg;
   cpmb_state_s st_next;

   // Decoded access and its qualifiers
   cpmb_dec_s   dec;
   logic        enh_mode;
   logic        tx_buf;
   logic        wr_ok;
   logic        rx_take;

   // Buffer indices of receive store and transmit view
   logic [2:0]  rb;
   logic [2:0]  ts;

   // Read mask and full-flag update vectors
   logic [7:0]  idl_mask;
   logic [5:0]  full_clr;
   logic [5:0]  full_set;

   // Next-state logic: register port, receive store, transmit view
   always_comb
   begin
      st_next           = st_reg;
      st_next.rd_data   = 8'h00;
      st_next.rx_accept = 1'b0;
      dec      = cpmb_decode(i_addr);
      rb       = i_rx_buf;
      ts       = i_tx_sel;

      // Flag vectors start empty every cycle
      full_clr = 6'h00;
      full_set = 6'h00;

      // Legacy mode hides every register of this block
      enh_mode = (i_op_mode == `CPMB_MODE_ENH1) ||
                 (i_op_mode == `CPMB_MODE_ENH2);

      // Addresses without a valid buffer index are neither transmit nor buffer-writable
      tx_buf   = 1'b0;
      wr_ok    = 1'b0;
      idl_mask = `CPMB_MASK_IDL_RX;
      if (cpmb_buf_ok(dec.buf_idx))
      begin
         tx_buf = st_reg.tx_dir[dec.buf_idx];
         // Writable only as an idle transmit buffer
         wr_ok  = tx_buf && !i_tx_locked[dec.buf_idx];
      end

      // Transmit id low also hides the unused request bit
      if (tx_buf)
      begin
         idl_mask = `CPMB_MASK_IDL_TX;
      end

      // Read path; unmapped or hidden addresses read zero
      if (i_rd && enh_mode)
      begin
         case (dec.kind)
            CPMB_REG_ID_HIGH:
            begin
               st_next.rd_data = st_reg.id_high[dec.buf_idx];
            end
            CPMB_REG_ID_LOW:
            begin
               st_next.rd_data = st_reg.id_low[dec.buf_idx] & idl_mask;
            end
            CPMB_REG_EXT_HIGH:
            begin
               st_next.rd_data = st_reg.ext_high[dec.buf_idx];
            end
            CPMB_REG_EXT_LOW:
            begin
               st_next.rd_data = st_reg.ext_low[dec.buf_idx];
            end
            CPMB_REG_LENGTH:
            begin
               st_next.rd_data = st_reg.length[dec.buf_idx] & `CPMB_MASK_LEN;
            end
            CPMB_REG_DATA:
            begin
               st_next.rd_data = st_reg.payload[dec.buf_idx][dec.byte_idx];
            end
            CPMB_REG_BSEL:
            begin
               st_next.rd_data = {st_reg.tx_dir, 2'b00};
            end
            // Full flags share the select register's bit layout
            CPMB_REG_FULL:
            begin
               st_next.rd_data = {st_reg.rx_full, 2'b00};
            end
            default:
            begin
               st_next.rd_data = 8'h00;
            end
         endcase
      end

      // Write path; receive buffers silently drop writes
      if (i_wr && enh_mode)
      begin
         case (dec.kind)
            CPMB_REG_ID_HIGH:
            begin
               if (wr_ok)
               begin
                  st_next.id_high[dec.buf_idx] = i_wdata;
               end
            end
            CPMB_REG_ID_LOW:
            begin
               if (wr_ok)
               begin
                  st_next.id_low[dec.buf_idx] = i_wdata & `CPMB_MASK_IDL_TX;
               end
            end
            CPMB_REG_EXT_HIGH:
            begin
               if (wr_ok)
               begin
                  st_next.ext_high[dec.buf_idx] = i_wdata;
               end
            end
            CPMB_REG_EXT_LOW:
            begin
               if (wr_ok)
               begin
                  st_next.ext_low[dec.buf_idx] = i_wdata;
               end
            end
            CPMB_REG_LENGTH:
            begin
               // Reserved codes are stored as written; software keeps to 0..8
               if (wr_ok)
               begin
                  st_next.length[dec.buf_idx] = i_wdata & `CPMB_MASK_LEN;
               end
            end
            CPMB_REG_DATA:
            begin
               if (wr_ok)
               begin
                  st_next.payload[dec.buf_idx][dec.byte_idx] = i_wdata;
               end
            end
            // Select and full-flag registers ignore the buffer lock
            CPMB_REG_BSEL:
            begin
               st_next.tx_dir = i_wdata[7:`CPMB_DIR_LSB];
            end
            CPMB_REG_FULL:
            begin
               full_clr = i_wdata[7:`CPMB_DIR_LSB];
            end
            default:
            begin
               full_clr = 6'h00;
            end
         endcase
      end

      // Receive store: only into a receive buffer that is not full
      rx_take = 1'b0;
      if (i_rx_store && cpmb_buf_ok(rb))
      begin
         rx_take = !st_reg.tx_dir[rb] && !st_reg.rx_full[rb];
      end

      // Fields of an accepted frame, laid out by frame kind
      if (rx_take)
      begin
         // All fields land on the same edge as the full flag
         if (i_rx_ext)
         begin
            st_next.id_high[rb]  = i_rx_id[28:21];
            st_next.id_low[rb]   = {i_rx_id[20:18], i_rx_srr, 1'b1,
                                    1'b0, i_rx_id[17:16]};
            st_next.ext_high[rb] = i_rx_id[15:8];
            st_next.ext_low[rb]  = i_rx_id[7:0];
         end
         else
         begin
            st_next.id_high[rb]  = i_rx_id[10:3];
            // Substitute request has no meaning in standard frames
            st_next.id_low[rb]   = {i_rx_id[2:0], 5'h00};
            // Extended bytes cleared so no stale identifier shows
            st_next.ext_high[rb] = 8'h00;
            st_next.ext_low[rb]  = 8'h00;
         end

         // Length and payload land with the identifier
         st_next.length[rb]  = {1'b0, i_rx_rtr, 2'b00, i_rx_dlc};
         st_next.payload[rb] = i_rx_data;
         full_set[rb]        = 1'b1;
         st_next.rx_accept   = 1'b1;
      end

      // A store in the clearing cycle keeps the flag set
      st_next.rx_full = (st_reg.rx_full & ~full_clr) | full_set;

      // Transmit view of the buffer the engine selects
      st_next.tx_id   = 29'h0;
      st_next.tx_ext  = 1'b0;
      st_next.tx_rtr  = 1'b0;
      st_next.tx_dlc  = 4'h0;
      st_next.tx_data = 64'h0;

      // Receive buffers and bad indices keep the zeros above
      if (cpmb_buf_ok(ts) && st_reg.tx_dir[ts])
      begin
         st_next.tx_ext = st_reg.id_low[ts][`CPMB_IDL_EXT];
         if (st_next.tx_ext)
         begin
            st_next.tx_id = {st_reg.id_high[ts], st_reg.id_low[ts][7:5],
                             st_reg.id_low[ts][1:0], st_reg.ext_high[ts],
                             st_reg.ext_low[ts]};
         end
         else
         begin
            st_next.tx_id = {18'h0, st_reg.id_high[ts],
                             st_reg.id_low[ts][7:5]};
         end

         // Request, length and payload of the viewed buffer
         st_next.tx_rtr  = st_reg.length[ts][`CPMB_LEN_RTR];
         st_next.tx_dlc  = st_reg.length[ts][3:0];
         st_next.tx_data = st_reg.payload[ts];
      end
   end

   // State register; contents are cleared too, though software must not rely on it
   always_ff @(posedge i_sys_clk)
   begin
      if (i_reset)
      begin
         st_reg        <= '0;
         st_reg.tx_dir <= `CPMB_BSEL_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign o_rdata      = st_reg.rd_data;
   assign o_rx_accept  = st_reg.rx_accept;
   assign o_rx_full    = st_reg.rx_full;
   assign o_buf_tx_dir = st_reg.tx_dir;
   assign o_tx_id      = st_reg.tx_id;
   assign o_tx_ext     = st_reg.tx_ext;
   assign o_tx_rtr     = st_reg.tx_rtr;
   assign o_tx_dlc     = st_reg.tx_dlc;
   assign o_tx_data    = st_reg.tx_data;

endmodule : cpmb_top

//--- verif/cpmb_engine_model.sv
// Protocol engine model that offers received frames to the buffers
`timescale 1ns/10ps

module cpmb_engine_model
(
   input  wire logic   i_sys_clk, // System clock
   output logic        o_store,   // Frame offer pulse
   output logic [2:0]  o_buf,     // Target buffer
   output logic [28:0] o_id,      // Identifier
   output logic        o_ext,     // Extended frame
   output logic        o_srr,     // Substitute remote request
   output logic        o_rtr,     // Remote request
   output logic [3:0]  o_dlc,     // Length code
   output logic [63:0] o_data     // Payload, byte 0 low
);
   initial {o_store, o_buf, o_id, o_ext, o_srr, o_rtr, o_dlc, o_data} = '0;

   // One-cycle offer; fields flip afterwards so stale values never look valid
   task send(input logic [2:0] b, input logic [28:0] id, input logic e, input logic s,
             input logic r, input logic [3:0] d, input logic [63:0] p);
      @(posedge i_sys_clk);
      {o_store, o_buf, o_id, o_ext, o_srr, o_rtr, o_dlc, o_data} <= {1'b1, b, id, e, s, r, d, p};
      @(posedge i_sys_clk);
      {o_store, o_buf, o_id, o_ext, o_srr, o_rtr, o_dlc, o_data} <=
         {1'b0, ~b, ~id, ~e, ~s, ~r, ~d, ~p};
   endtask : send
endmodule : cpmb_engine_model

//--- verif/cpmb_top_asserts.sv
// Port checker for the message buffer block
`timescale 1ns/10ps

module cpmb_top_asserts
(
   input wire logic        i_sys_clk,    // Clock
   input wire logic        i_reset,      // Reset
   input wire logic [1:0]  i_op_mode,    // Operating mode
   input wire logic [7:0]  i_addr,       // Address
   input wire logic        i_rd,         // Read strobe
   input wire logic [7:0]  o_rdata,      // Read data
   input wire logic        i_rx_store,   // Frame offer
   input wire logic [2:0]  i_rx_buf,     // Target buffer
   input wire logic        o_rx_accept,  // Store pulse
   input wire logic [5:0]  o_rx_full,    // Full flags
   input wire logic [5:0]  o_buf_tx_dir, // Directions
   input wire logic [2:0]  i_tx_sel,     // Viewed buffer
   input wire logic [28:0] o_tx_id,      // Viewed identifier
   input wire logic [3:0]  o_tx_dlc      // Viewed length
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   // Register port live only in the enhanced modes
   logic en;
   assign en = (i_op_mode == 2'h1) || (i_op_mode == 2'h2);

   // Offer to a free receive buffer, then stored with its flag
   sequence s_offer;
      i_rx_store && i_rx_buf < 3'h6 && !o_buf_tx_dir[i_rx_buf] && !o_rx_full[i_rx_buf];
   endsequence
   sequence s_kept;
      o_rx_accept && o_rx_full[$past(i_rx_buf)];
   endsequence

   property p_rd_idle;
      !i_rd |=> o_rdata == 8'h00;
   endproperty
   property p_legacy;
      i_rd && i_op_mode == 2'h0 |=> o_rdata == 8'h00;
   endproperty
   property p_bsel;
      i_rd && en && i_addr == 8'h60 |=> o_rdata == {$past(o_buf_tx_dir), 2'b00};
   endproperty
   property p_idl;
      i_rd && en && i_addr[7:4] < 4'h6 && i_addr[3:0] == 4'h1 |=> !o_rdata[2];
   endproperty
   property p_len;
      i_rd && en && i_addr[7:4] < 4'h6 && i_addr[3:0] == 4'h4 |=> o_rdata[7:4] == 4'h0
         || o_rdata[7:4] == 4'h4;
   endproperty
   property p_accept;
      s_offer |=> s_kept;
   endproperty
   property p_full_block;
      i_rx_store && i_rx_buf < 3'h6 && o_rx_full[i_rx_buf] |=> !o_rx_accept;
   endproperty
   property p_view_rx;
      i_tx_sel < 3'h6 && !o_buf_tx_dir[i_tx_sel] |=> o_tx_id == 29'h0 && o_tx_dlc == 4'h0;
   endproperty

   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
   a_legacy: assert property (p_legacy) else $error("legacy mode read not zero");
   a_bsel: assert property (p_bsel) else $error("direction select readback wrong");
   a_idl: assert property (p_idl) else $error("id low bit 2 not zero");
   a_len: assert property (p_len) else $error("length reserved bits set");
   a_accept: assert property (p_accept) else $error("free buffer did not store");
   a_full_block: assert property (p_full_block) else $error("full buffer stored");
   a_view_rx: assert property (p_view_rx) else $error("receive buffer shown as send");
endmodule : cpmb_top_asserts

bind cpmb_top cpmb_top_asserts i_chk
(
   .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_op_mode(i_op_mode), .i_addr(i_addr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_store(i_rx_store), .i_rx_buf(i_rx_buf),
   .o_rx_accept(o_rx_accept), .o_rx_full(o_rx_full), .o_buf_tx_dir(o_buf_tx_dir),
   .i_tx_sel(i_tx_sel), .o_tx_id(o_tx_id), .o_tx_dlc(o_tx_dlc)
);

//--- verif/testbench.sv
// Self-checking bench for the programmable message buffers
`timescale 1ns/10ps

module testbench;
   logic        i_sys_clk = 1'b0;
   logic        i_reset = 1'b1;
   logic [1:0]  i_op_mode = 2'h1;
   logic [7:0]  i_addr = 8'h00;
   logic [7:0]  i_wdata = 8'h00;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [5:0]  i_tx_locked = 6'h00;
   logic [2:0]  i_tx_sel = 3'h0;
   logic [7:0]  o_rdata;
   logic [5:0]  o_rx_full, o_buf_tx_dir;
   logic        o_rx_accept, o_tx_ext, o_tx_rtr, e_store, e_ext, e_srr, e_rtr;
   logic [28:0] o_tx_id, e_id;
   logic [3:0]  o_tx_dlc, e_dlc;
   logic [63:0] o_tx_data, e_data, dat;
   logic [2:0]  e_buf;
   logic [7:0]  lo;
   int          num_errors = 0;
   int          num_checks = 0;
   localparam logic [28:0] XID = 29'h1abcde57;
   localparam logic [63:0] PAY = 64'h8877665544332211;

   always #4 i_sys_clk = ~i_sys_clk;

   cpmb_engine_model i_eng (.i_sys_clk(i_sys_clk), .o_store(e_store), .o_buf(e_buf),
      .o_id(e_id), .o_ext(e_ext), .o_srr(e_srr), .o_rtr(e_rtr), .o_dlc(e_dlc), .o_data(e_data));

   cpmb_top i_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_op_mode(i_op_mode),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_tx_locked(i_tx_locked), .i_rx_store(e_store), .i_rx_buf(e_buf), .i_rx_id(e_id),
      .i_rx_ext(e_ext), .i_rx_srr(e_srr), .i_rx_rtr(e_rtr), .i_rx_dlc(e_dlc),
      .i_rx_data(e_data), .o_rx_accept(o_rx_accept), .o_rx_full(o_rx_full),
      .o_buf_tx_dir(o_buf_tx_dir), .i_tx_sel(i_tx_sel), .o_tx_id(o_tx_id),
      .o_tx_ext(o_tx_ext), .o_tx_rtr(o_tx_rtr), .o_tx_dlc(o_tx_dlc), .o_tx_data(o_tx_data));

   // Test pattern per buffer and register
   function automatic logic [7:0] pv(input int n, input int k);
      return 8'(n * 37 + k * 29 + 8);
   endfunction : pv

   // Length with unimplemented bits set; codes kept within 0..8
   function automatic logic [7:0] ln(input int n);
      return 8'hb0 | 8'((n % 2) * 64 + n + 3);
   endfunction : ln

   task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
      #1;
   endtask : wr

   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 chk($sformatf("read %h", a), 64'(exp), 64'(o_rdata));
   endtask : rd

   task give_verdict;
      $display("checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   // Hang guard, far beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      num_errors++;
      give_verdict();
   end

   // Main sequence
   initial
   begin
      repeat (3) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      rd(8'h60, 8'h00);
      i_op_mode <= 2'h0;
      wr(8'h60, 8'hfc);
      rd(8'h60, 8'h00);
      i_op_mode <= 2'h2;
      rd(8'h60, 8'h00);
      wr(8'h60, 8'hff);
      rd(8'h60, 8'hfc);
      chk("direction", 64'h3f, 64'(o_buf_tx_dir));
      // Send buffers: fill, read back through masks, view as the engine does
      for (int n = 0; n < 6; n++)
      begin
         for (int k = 0; k < 16; k++)
            if (k < 5 || k > 7) wr(8'(n * 16 + k), k == 4 ? ln(n) : pv(n, k));
         for (int k = 0; k < 16; k++)
            if (k < 5 || k > 7) rd(8'(n * 16 + k), k == 4 ? ln(n) & 8'h4f : k == 1 ?
               pv(n, k) & 8'heb : pv(n, k));
         i_tx_sel <= 3'(n);
         repeat (2) @(posedge i_sys_clk);
         #1 lo = pv(n, 1);
         for (int m = 0; m < 8; m++)
            dat[8 * m +: 8] = pv(n, 8 + m);
         chk("tx id", lo[3] ? {pv(n, 0), lo[7:5], lo[1:0], pv(n, 2), pv(n, 3)} :
            {18'h0, pv(n, 0), lo[7:5]}, 64'(o_tx_id));
         chk("tx flags", {n[0], lo[3], 4'(n + 3)}, {o_tx_rtr, o_tx_ext, o_tx_dlc});
         chk("tx data", dat, o_tx_data);
      end
      i_tx_locked <= 6'h02;
      wr(8'h10, 8'h00);
      rd(8'h10, pv(1, 0));
      i_tx_locked <= 6'h00;
      for (int d = 0; d < 9; d++)
      begin
         wr(8'h04, 8'(d));
         rd(8'h04, 8'(d));
      end
      // Receive side: software writes dropped, engine stores frames
      wr(8'h60, 8'h00);
      wr(8'h20, 8'h00);
      wr(8'h28, 8'h00);
      rd(8'h20, pv(2, 0));
      rd(8'h28, pv(2, 8));
      i_eng.send(3'h2, XID, 1'b1, 1'b1, 1'b0, 4'h8, PAY);
      #1 chk("accept", 64'h3, {o_rx_accept, o_rx_full[2]});
      rd(8'h20, XID[28:21]);
      rd(8'h21, {XID[20:18], 3'b110, XID[17:16]});
      rd(8'h22, XID[15:8]);
      rd(8'h23, XID[7:0]);
      rd(8'h24, 8'h08);
      for (int m = 0; m < 8; m++)
         rd(8'(8'h28 + m), PAY[8 * m +: 8]);
      i_eng.send(3'h2, 29'h5a3, 1'b0, 1'b0, 1'b1, 4'h0, 64'h0);
      #1 chk("accept", 64'h0, 64'(o_rx_accept));
      rd(8'h20, XID[28:21]);
      i_eng.send(3'h3, 29'h5a3, 1'b0, 1'b1, 1'b1, 4'h0, 64'h0);
      rd(8'h30, 8'hb4);
      rd(8'h31, 8'h60);
      rd(8'h32, 8'h00);
      rd(8'h34, 8'h40);
      wr(8'h61, 8'h10);
      chk("full", 64'h0, 64'(o_rx_full[2]));
      i_eng.send(3'h2, 29'h5a3, 1'b0, 1'b0, 1'b0, 4'h1, 64'h0);
      rd(8'h61, 8'h30);
      rd(8'h20, 8'hb4);
      rd(8'h70, 8'h00);
      give_verdict();
   end
endmodule : testbench
